// ===== verilog/sgs_status.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// - Monitor bits show outputs after the settle timers but before output polarity.
// - Torque-under monitor is 1 when torque command is at or below limit.
// - Velocity-error-over monitor reads 1 at or above the limit.
// - Velocity-error-under monitors read 1 at or below the limit.
// - The warning monitor is 0 normally and 1 while a warning is present.
// - Each zone monitor A, B, C is 1 while the motor is inside that zone.
// - Width sign: <0 held, 0 error-based, >0 pulsed; default -1.0 ms.
// - Held mode keeps completion off |width| after start, then holds it.
// - Error-based mode drives completion from the current position error.
// - Pulsed mode emits a completion pulse of set width, 0.1 to 10000 ms.
// - Phase Z format 0 is index pulse, 1 is MSB format; default 0.
// - Gain threshold 0 disables switching, else 1 to 2621439; default 0.
// - Stationary gain after error stays at or below threshold for delay.
// - Gain delay is 0.0 to 10000.0 ms, default 0.0, a stability timer.
// - Home acceleration accepts 0.1 to 800.0 and defaults to 1.0.
// - Home decel 0.0, the default, uses acceleration; else 0.1 to 800.0.
module sgs_status
  import sgs_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  input  wire logic [5:0]        avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  input  wire logic [3:0]        avs_byteenable_in,
  output logic [31:0]            avs_readdata_out,
  output logic                   avs_waitrequest_out,
  output logic                   irq_out,
  input  wire logic              torque_under_flag_in,
  input  wire logic              vel_err_over_flag_in,
  input  wire logic              vel_err_under_flag_in,
  input  wire logic              vel_err_under_alt_flag_in,
  input  wire logic              warning_flag_in,
  input  wire logic              region_a_flag_in,
  input  wire logic              region_b_flag_in,
  input  wire logic              region_c_flag_in,
  input  wire logic              pos_start_in,
  input  wire logic              pos_done_in,
  input  wire logic              pos_err_ok_in,
  input  wire logic [ERR_W-1:0]  pos_err_mag_in,
  input  wire logic              index_pulse_in,
  input  wire logic              index_msb_in,
  output logic                   in_position_output_out,
  output logic                   phase_z_out,
  output logic                   stationary_gain_out,
  output logic [ACC_W-1:0]       home_accel_out,
  output logic [ACC_W-1:0]       home_decel_eff_out
);

  if (TICK_CYCLES_P < 2) begin : g_bad_tick
    $error("sgs_status: TICK_CYCLES_P must be at least 2");
  end

  // Parameter registers
  logic signed [31:0] completion_width_reg;
  logic               index_pulse_format_reg;
  logic [THR_W-1:0]   gain_switch_threshold_reg;
  logic [TIME_W-1:0]  gain_switch_delay_reg;
  logic [ACC_W-1:0]   home_accel_reg;
  logic [ACC_W-1:0]   home_decel_reg;
  logic               output_polarity_reg;
  logic [IRQ_W-1:0]   irq_status_reg;
  logic [IRQ_W-1:0]   irq_mask_reg;
  logic [MON_W-3:0]   monitor_reg;
  logic               in_position_output_raw_reg;

  // Bus handshake
  logic               access_reg;
  logic [IRQ_W-1:0]   irq_taken_reg;
  logic               req;
  logic               done_access;
  logic               wr_en;
  logic               rd_status;
  logic [31:0]        rd_next;

  assign req         = avs_read_in || avs_write_in;
  assign done_access = req && access_reg;
  assign wr_en       = avs_write_in && access_reg && (&avs_byteenable_in);
  assign rd_status   = avs_read_in && access_reg
                       && avs_address_in == OFF_IRQ_STATUS;

  // Every access: one wait cycle, completes on the second edge
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      access_reg          <= 1'b0;
      avs_waitrequest_out <= 1'b1;
    end else if (req && !access_reg) begin
      access_reg          <= 1'b1;
      avs_waitrequest_out <= 1'b0;
    end else begin
      access_reg          <= 1'b0;
      avs_waitrequest_out <= 1'b1;
    end
  end

  always_comb begin
    rd_next = 32'h0000_0000;
    case (avs_address_in)
      OFF_MONITOR:    rd_next[MON_W-1:0] = {stationary_gain_out,
                                            in_position_output_raw_reg, monitor_reg};
      OFF_CPL_WIDTH:  rd_next = completion_width_reg;
      OFF_INDEX_FMT:  rd_next[0] = index_pulse_format_reg;
      OFF_GAIN_THR:   rd_next[THR_W-1:0] = gain_switch_threshold_reg;
      OFF_GAIN_DELAY: rd_next[TIME_W-1:0] = gain_switch_delay_reg;
      OFF_HOME_ACCEL: rd_next[ACC_W-1:0] = home_accel_reg;
      OFF_HOME_DECEL: rd_next[ACC_W-1:0] = home_decel_reg;
      OFF_DECEL_EFF:  rd_next[ACC_W-1:0] = home_decel_eff_out;
      OFF_IRQ_STATUS: rd_next[IRQ_W-1:0] = irq_status_reg;
      OFF_IRQ_MASK:   rd_next[IRQ_W-1:0] = irq_mask_reg;
      OFF_OUT_POL:    rd_next[0] = output_polarity_reg;
      default:        rd_next = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the wait cycle and stands at completion
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h0000_0000;
      irq_taken_reg    <= '0;
    end else if (avs_read_in && !access_reg) begin
      avs_readdata_out <= rd_next;
      irq_taken_reg    <= rd_next[IRQ_W-1:0];
    end
  end

  // Writes outside the documented range leave the width, gain and home registers unchanged; other registers take bit 0 or the low bits
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      completion_width_reg      <= CPL_WIDTH_RST;
      index_pulse_format_reg    <= INDEX_FMT_RST;
      gain_switch_threshold_reg <= GAIN_THR_RST;
      gain_switch_delay_reg     <= GAIN_DELAY_RST;
      home_accel_reg            <= HOME_ACCEL_RST;
      home_decel_reg            <= HOME_DECEL_RST;
      output_polarity_reg       <= 1'b0;
      irq_mask_reg              <= '0;
    end else if (wr_en) begin
      case (avs_address_in)
        OFF_CPL_WIDTH: begin
          if ($signed(avs_writedata_in) >= -CPL_WIDTH_MAX
              && $signed(avs_writedata_in) <= CPL_WIDTH_MAX) begin
            completion_width_reg <= $signed(avs_writedata_in);
          end
        end
        OFF_INDEX_FMT: begin
          index_pulse_format_reg <= avs_writedata_in[0];
        end
        OFF_GAIN_THR: begin
          if (avs_writedata_in <= 32'(GAIN_THR_MAX)) begin
            gain_switch_threshold_reg <= avs_writedata_in[THR_W-1:0];
          end
        end
        OFF_GAIN_DELAY: begin
          if (avs_writedata_in <= 32'(GAIN_DELAY_MAX)) begin
            gain_switch_delay_reg <= avs_writedata_in[TIME_W-1:0];
          end
        end
        OFF_HOME_ACCEL: begin
          if (avs_writedata_in >= 32'(ACCEL_MIN)
              && avs_writedata_in <= 32'(ACCEL_MAX)) begin
            home_accel_reg <= avs_writedata_in[ACC_W-1:0];
          end
        end
        OFF_HOME_DECEL: begin
          if (avs_writedata_in <= 32'(ACCEL_MAX)) begin
            home_decel_reg <= avs_writedata_in[ACC_W-1:0];
          end
        end
        OFF_IRQ_MASK: begin
          irq_mask_reg <= avs_writedata_in[IRQ_W-1:0];
        end
        OFF_OUT_POL: begin
          output_polarity_reg <= avs_writedata_in[0];
        end
        default: begin
        end
      endcase
    end
  end

  // Monitors sample the raw detector levels every cycle
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      monitor_reg <= '0;
    end else begin
      monitor_reg[MON_TORQUE_UNDER]  <= torque_under_flag_in;
      monitor_reg[MON_VEL_ERR_OVER]  <= vel_err_over_flag_in;
      monitor_reg[MON_VEL_ERR_UNDER] <= vel_err_under_flag_in;
      monitor_reg[MON_VEL_ERR_ALT]   <= vel_err_under_alt_flag_in;
      monitor_reg[MON_WARNING]       <= warning_flag_in;
      monitor_reg[MON_REGION_A]      <= region_a_flag_in;
      monitor_reg[MON_REGION_B]      <= region_b_flag_in;
      monitor_reg[MON_REGION_C]      <= region_c_flag_in;
    end
  end

  // Completion notice
  sgs_cmp_state_t    cmp_state_reg;
  logic              mode_held;
  logic              mode_error;
  logic              mode_pulsed;
  logic [TIME_W-1:0] width_abs;
  logic              cpl_run;
  logic              cpl_reached;
  logic              in_position_output_next;

  assign mode_held   = completion_width_reg < 0;
  assign mode_error  = completion_width_reg == 32'sd0;
  assign mode_pulsed = completion_width_reg > 0;
  assign width_abs   = mode_held ? TIME_W'(-completion_width_reg)
                                 : TIME_W'(completion_width_reg);
  assign cpl_run     = mode_held ? (cmp_state_reg == CS_MOVING
                                    || cmp_state_reg == CS_WAIT)
                                 : (mode_pulsed
                                    && cmp_state_reg == CS_DONE);

  sgs_stab_timer #(
    .TICK_CYCLES (TICK_CYCLES_P),
    .CNT_W       (TIME_W)
  ) u_cpl_timer (
    .ref_clk_in  (ref_clk_in),
    .rst_in      (rst_in),
    .run_in      (cpl_run),
    .limit_in    (width_abs),
    .reached_out (cpl_reached)
  );

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmp_state_reg <= CS_IDLE;
    end else if (pos_start_in) begin
      cmp_state_reg <= CS_MOVING;
    end else begin
      case (cmp_state_reg)
        CS_IDLE: begin
          cmp_state_reg <= CS_IDLE;
        end
        CS_MOVING: begin
          if (pos_done_in) begin
            cmp_state_reg <= mode_held ? CS_WAIT : CS_DONE;
          end
        end
        CS_WAIT: begin
          if (cpl_reached) begin
            cmp_state_reg <= CS_DONE;
          end
        end
        CS_DONE: begin
          if (mode_pulsed && cpl_reached) begin
            cmp_state_reg <= CS_IDLE;
          end
        end
        default: begin
          cmp_state_reg <= CS_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    in_position_output_next = 1'b0;
    if (mode_held) begin
      in_position_output_next = cmp_state_reg == CS_DONE
                  || cmp_state_reg == CS_IDLE;
    end else if (mode_error) begin
      in_position_output_next = (cmp_state_reg == CS_DONE
                   || cmp_state_reg == CS_IDLE)
                  && pos_err_ok_in;
    end else begin
      in_position_output_next = cmp_state_reg == CS_DONE;
    end
  end

  // Monitor holds the raw level, the pin gets the polarity
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      in_position_output_raw_reg           <= 1'b0;
      in_position_output_out <= 1'b0;
    end else begin
      in_position_output_raw_reg           <= in_position_output_next;
      in_position_output_out <= in_position_output_next ^ output_polarity_reg;
    end
  end

  // Automatic gain switching
  logic gain_run;
  logic gain_reached;

  assign gain_run = gain_switch_threshold_reg != '0
                    && pos_err_mag_in <= ERR_W'(gain_switch_threshold_reg);

  sgs_stab_timer #(
    .TICK_CYCLES (TICK_CYCLES_P),
    .CNT_W       (TIME_W)
  ) u_gain_timer (
    .ref_clk_in  (ref_clk_in),
    .rst_in      (rst_in),
    .run_in      (gain_run),
    .limit_in    (gain_switch_delay_reg),
    .reached_out (gain_reached)
  );

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stationary_gain_out <= 1'b0;
    end else begin
      stationary_gain_out <= gain_reached && gain_run;
    end
  end

  // Phase Z format and home-return settings
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_z_out        <= 1'b0;
      home_accel_out     <= HOME_ACCEL_RST;
      home_decel_eff_out <= HOME_ACCEL_RST;
    end else begin
      phase_z_out        <= index_pulse_format_reg ? index_msb_in
                                                   : index_pulse_in;
      home_accel_out     <= home_accel_reg;
      home_decel_eff_out <= (~|home_decel_reg) ? home_accel_reg
                                               : home_decel_reg;
    end
  end

  // Interrupts: rising events set, a status read clears what it returned
  logic [IRQ_W-1:0] irq_set;

  assign irq_set[IRQ_COMPLETION] = in_position_output_next
                                   && !in_position_output_raw_reg;
  assign irq_set[IRQ_WARNING]    = warning_flag_in
                                   && !monitor_reg[MON_WARNING];
  assign irq_set[IRQ_GAIN_SW]    = gain_reached && gain_run
                                   && !stationary_gain_out;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_status_reg <= '0;
    end else if (rd_status) begin
      irq_status_reg <= (irq_status_reg & ~irq_taken_reg) | irq_set;
    end else begin
      irq_status_reg <= irq_status_reg | irq_set;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_status_reg & irq_mask_reg);
    end
  end

endmodule

`default_nettype wire

// ===== verilog/sgs_pkg.sv
package sgs_pkg;

  // Register byte offsets
  localparam logic [5:0] OFF_MONITOR     = 6'h00;
  localparam logic [5:0] OFF_CPL_WIDTH   = 6'h04;
  localparam logic [5:0] OFF_INDEX_FMT   = 6'h08;
  localparam logic [5:0] OFF_GAIN_THR    = 6'h0C;
  localparam logic [5:0] OFF_GAIN_DELAY  = 6'h10;
  localparam logic [5:0] OFF_HOME_ACCEL  = 6'h14;
  localparam logic [5:0] OFF_HOME_DECEL  = 6'h18;
  localparam logic [5:0] OFF_DECEL_EFF   = 6'h1C;
  localparam logic [5:0] OFF_IRQ_STATUS  = 6'h20;
  localparam logic [5:0] OFF_IRQ_MASK    = 6'h24;
  localparam logic [5:0] OFF_OUT_POL     = 6'h28;

  // Monitor register bit positions
  localparam int MON_TORQUE_UNDER  = 0;
  localparam int MON_VEL_ERR_OVER  = 1;
  localparam int MON_VEL_ERR_UNDER = 2;
  localparam int MON_VEL_ERR_ALT   = 3;
  localparam int MON_WARNING       = 4;
  localparam int MON_REGION_A      = 5;
  localparam int MON_REGION_B      = 6;
  localparam int MON_REGION_C      = 7;
  localparam int MON_IN_POSITION   = 8;
  localparam int MON_STATIONARY    = 9;
  localparam int MON_W             = 10;

  // Interrupt status bit positions
  localparam int IRQ_COMPLETION = 0;
  localparam int IRQ_WARNING    = 1;
  localparam int IRQ_GAIN_SW    = 2;
  localparam int IRQ_W          = 3;

  // Field widths and ranges (times in 0.1 ms, accel in 0.1 s^-2)
  localparam int TIME_W = 17;
  localparam int THR_W  = 22;
  localparam int ERR_W  = 24;
  localparam int ACC_W  = 13;
  localparam logic signed [31:0] CPL_WIDTH_MAX  = 32'sd100000;
  localparam logic [TIME_W-1:0]  GAIN_DELAY_MAX = 17'd100000;
  localparam logic [THR_W-1:0]   GAIN_THR_MAX   = 22'd2621439;
  localparam logic [ACC_W-1:0]   ACCEL_MIN      = 13'd1;
  localparam logic [ACC_W-1:0]   ACCEL_MAX      = 13'd8000;

  // Reset values
  localparam logic signed [31:0] CPL_WIDTH_RST  = -32'sd10;
  localparam logic               INDEX_FMT_RST  = 1'b0;
  localparam logic [THR_W-1:0]   GAIN_THR_RST   = 22'd0;
  localparam logic [TIME_W-1:0]  GAIN_DELAY_RST = 17'd0;
  localparam logic [ACC_W-1:0]   HOME_ACCEL_RST = 13'd10;
  localparam logic [ACC_W-1:0]   HOME_DECEL_RST = 13'd0;

  // Timing: one timer tick is 0.1 ms
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_TIME_US  = 100;
  localparam int TICK_CYCLES   = TICK_TIME_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    CS_IDLE   = 2'b00,
    CS_MOVING = 2'b01,
    CS_WAIT   = 2'b11,
    CS_DONE   = 2'b10
  } sgs_cmp_state_t;

endpackage

// ===== verilog/sgs_stab_timer.sv
`timescale 1ns/1ps
`default_nettype none

module sgs_stab_timer
  import sgs_pkg::*;
#(
  parameter int TICK_CYCLES = 10000,
  parameter int CNT_W       = 17
) (
  input  wire logic             ref_clk_in,
  input  wire logic             rst_in,
  input  wire logic             run_in,
  input  wire logic [CNT_W-1:0] limit_in,
  output logic                  reached_out
);

  localparam int PRE_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("sgs_stab_timer: TICK_CYCLES must be at least 1");
  end

  logic [PRE_W-1:0] pre_reg;
  logic [CNT_W-1:0] cnt_reg;

  // Prescaler restarts with the run level so the first tick is a full one
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_reg <= '0;
    end else if (!run_in || pre_reg == PRE_LAST) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg     <= '0;
      reached_out <= 1'b0;
    end else if (!run_in) begin
      cnt_reg     <= '0;
      reached_out <= 1'b0;
    end else if (cnt_reg >= limit_in) begin
      reached_out <= 1'b1;
    end else if (pre_reg == PRE_LAST) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

endmodule

`default_nettype wire

// ===== dv/sgs_status_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sgs_status_asserts
  import sgs_pkg::*;
(
  input wire logic             ref_clk_in,
  input wire logic             rst_in,
  input wire logic             avs_read_in,
  input wire logic             avs_write_in,
  input wire logic [31:0]      avs_readdata_out,
  input wire logic             avs_waitrequest_out,
  input wire logic             index_pulse_in,
  input wire logic             index_msb_in,
  input wire logic             phase_z_out,
  input wire logic [ERR_W-1:0] pos_err_mag_in,
  input wire logic             stationary_gain_out,
  input wire logic [ACC_W-1:0] home_accel_out,
  input wire logic [ACC_W-1:0] home_decel_eff_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_req;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_ack;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  a_req_answer: assert property (s_req |=> s_ack)
    else $error("bus request not answered after one wait cycle");
  a_idle_wait: assert property (
      !avs_read_in && !avs_write_in |=> avs_waitrequest_out)
    else $error("waitrequest low without a request");
  a_rdata_hold: assert property (
      !$stable(avs_readdata_out) |-> $past(avs_read_in))
    else $error("read data changed without a read");
  a_accel_range: assert property (
      home_accel_out >= ACCEL_MIN && home_accel_out <= ACCEL_MAX)
    else $error("home acceleration out of range");
  a_decel_range: assert property (
      home_decel_eff_out >= ACCEL_MIN && home_decel_eff_out <= ACCEL_MAX)
    else $error("effective deceleration zero or out of range");
  a_phase_src: assert property (
      !$past(rst_in) |-> phase_z_out == $past(index_pulse_in)
                         || phase_z_out == $past(index_msb_in))
    else $error("phase Z output from no source");
  a_stat_off: assert property (
      pos_err_mag_in > GAIN_THR_MAX |-> ##[1:2] !stationary_gain_out)
    else $error("stationary gain held with large error");
  a_stat_rise: assert property (
      $rose(stationary_gain_out) |-> $past(pos_err_mag_in, 2) <= GAIN_THR_MAX)
    else $error("stationary gain engaged with large error");
endmodule
`default_nettype wire

// ===== dv/sgs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sgs_host_model (
  input  wire logic  ref_clk_in,
  input  wire logic  wait_in,
  output logic [5:0] addr_out,
  output logic       rd_out,
  output logic       wr_out,
  output logic [31:0] wdata_out,
  output logic [3:0] be_out,
  output logic       hang_out
);
  initial begin
    addr_out = 6'h00;
    rd_out = 1'b0;
    wr_out = 1'b0;
    wdata_out = 32'h0;
    be_out = 4'h0;
    hang_out = 1'b0;
  end
  task automatic xfer(input logic [5:0] a, input logic w,
                      input logic [31:0] d, input logic [3:0] b);
    int n;
    @(posedge ref_clk_in);
    addr_out <= a;
    rd_out <= !w;
    wr_out <= w;
    wdata_out <= d;
    be_out <= b;
    n = 0;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (wait_in !== 1'b0 && n < 50);
    if (wait_in !== 1'b0) hang_out <= 1'b1;
    rd_out <= 1'b0;
    wr_out <= 1'b0;
    // Released lines show garbage, not the last value
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
endmodule
`default_nettype wire

// ===== dv/tb_servo_status_inposition_gain_switch.sv
`timescale 1ns/1ps
`default_nettype none
module tb_servo_status_inposition_gain_switch
  import sgs_pkg::*;
;
  localparam int TK = 4;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  localparam logic [5:0] ADR [9] = '{OFF_CPL_WIDTH, OFF_INDEX_FMT,
    OFF_GAIN_THR, OFF_GAIN_DELAY, OFF_HOME_ACCEL, OFF_HOME_DECEL,
    OFF_DECEL_EFF, OFF_IRQ_MASK, 6'h2C};
  localparam logic [31:0] VAL [9] = '{32'hFFFFFFF6, 32'h0, 32'h0,
    32'h0, 32'hA, 32'h0, 32'hA, 32'h0, 32'h0};
  logic             ref_clk = 1'b0;
  logic             rst     = 1'b1;
  logic [7:0]       flags   = 8'h00;
  logic             start   = 1'b0;
  logic             done    = 1'b0;
  logic             err_ok  = 1'b0;
  logic [ERR_W-1:0] err_mag = 24'h0;
  logic             idx_p   = 1'b0;
  logic             idx_m   = 1'b0;
  logic [5:0]       addr;
  logic             rd_o, wr_o, wq, irq, in_position_output, phz, stat, hang;
  logic [31:0]      wdata, rdata, e, m, x;
  logic [3:0]       be;
  logic [ACC_W-1:0] acc, dec;
  logic [31:0]      qe[$], qm[$];
  int               seed = 29;
  int               fails = 0;
  int               checks_done = 0;
  int               n;
  always #5 ref_clk = ~ref_clk;
  sgs_host_model u_host (.ref_clk_in(ref_clk), .wait_in(wq),
    .addr_out(addr), .rd_out(rd_o), .wr_out(wr_o), .wdata_out(wdata),
    .be_out(be), .hang_out(hang));
  sgs_status #(.TICK_CYCLES_P(TK)) u_dut (
    .ref_clk_in(ref_clk), .rst_in(rst), .avs_address_in(addr),
    .avs_read_in(rd_o), .avs_write_in(wr_o), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wq), .irq_out(irq),
    .torque_under_flag_in(flags[0]), .vel_err_over_flag_in(flags[1]),
    .vel_err_under_flag_in(flags[2]), .vel_err_under_alt_flag_in(flags[3]),
    .warning_flag_in(flags[4]), .region_a_flag_in(flags[5]),
    .region_b_flag_in(flags[6]), .region_c_flag_in(flags[7]),
    .pos_start_in(start), .pos_done_in(done), .pos_err_ok_in(err_ok),
    .pos_err_mag_in(err_mag), .index_pulse_in(idx_p), .index_msb_in(idx_m),
    .in_position_output_out(in_position_output), .phase_z_out(phz),
    .stationary_gain_out(stat), .home_accel_out(acc),
    .home_decel_eff_out(dec));
  task check(input logic [31:0] s, input logic [31:0] w);
    checks_done++;
    if (s !== w) begin
      fails++;
      $display("unexpected at %0t: saw %h expected %h", $time, s, w);
    end
  endtask
  task summarize;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d);
    u_host.xfer(a, 1'b1, d, 4'hF);
  endtask
  task rd(input logic [5:0] a, input logic [31:0] w, input logic [31:0] k);
    qe.push_back(w);
    qm.push_back(k);
    u_host.xfer(a, 1'b0, 32'h0, 4'hF);
  endtask
  task cyc(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  task pulse_pos(input int gap);
    @(posedge ref_clk) start <= 1'b1;
    @(posedge ref_clk) start <= 1'b0;
    repeat (gap) @(posedge ref_clk);
    done <= 1'b1;
    @(posedge ref_clk) done <= 1'b0;
  endtask
  task automatic await_lvl(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 80) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 80) begin
      fails++;
      summarize();
    end
  endtask
  // Read data are compared against the oldest note
  always @(posedge ref_clk) begin
    if (rd_o && wq === 1'b0) begin
      e = qe.pop_front();
      m = qm.pop_front();
      check(rdata & m, e);
    end
  end
  always @(posedge hang) begin
    fails++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (ADR[i]) begin
      rd(ADR[i], VAL[i], ALL);
    end
    check(32'(acc), 32'hA);
    check(32'(dec), 32'hA);
    rd(OFF_IRQ_STATUS, 32'h1, ALL);
    wr(OFF_IRQ_MASK, 32'h2);
    @(posedge ref_clk) flags[4] <= 1'b1;
    cyc(4);
    check(32'(irq), 32'h1);
    wr(OFF_IRQ_MASK, 32'h0);
    cyc(2);
    check(32'(irq), 32'h0);
    wr(OFF_IRQ_MASK, 32'h2);
    rd(OFF_IRQ_STATUS, 32'h2, 32'h2);
    cyc(2);
    check(32'(irq), 32'h0);
    rd(OFF_IRQ_STATUS, 32'h0, 32'h2);
    wr(OFF_MONITOR, ALL);
    repeat (6) begin
      @(posedge ref_clk) flags <= 8'($random(seed));
      cyc(1);
      x = {22'h0, 2'b01, flags};
      rd(OFF_MONITOR, x, ALL);
    end
    wr(OFF_HOME_ACCEL, 32'h1F41);
    u_host.xfer(OFF_HOME_ACCEL, 1'b1, 32'h5, 4'h7);
    wr(OFF_HOME_DECEL, 32'h1F41);
    rd(OFF_HOME_ACCEL, 32'hA, ALL);
    rd(OFF_HOME_DECEL, 32'h0, ALL);
    wr(OFF_HOME_ACCEL, 32'h1F40);
    wr(OFF_HOME_ACCEL, 32'h0);
    cyc(2);
    check(32'(acc), 32'h1F40);
    check(32'(dec), 32'h1F40);
    wr(OFF_HOME_DECEL, 32'h1);
    cyc(2);
    check(32'(dec), 32'h1);
    rd(OFF_DECEL_EFF, 32'h1, ALL);
    for (int f = 0; f < 2; f++) begin
      wr(OFF_INDEX_FMT, 32'(f));
      repeat (4) begin
        @(posedge ref_clk) {idx_p, idx_m} <= 2'($random(seed));
        cyc(2);
        check(32'(phz), 32'(f ? idx_m : idx_p));
      end
    end
    wr(OFF_CPL_WIDTH, 32'h2);
    pulse_pos(3);
    await_lvl(in_position_output, 1'b1);
    await_lvl(in_position_output, 1'b0);
    check(32'(n >= 2 * TK && n <= 2 * TK + 2), 32'h1);
    wr(OFF_CPL_WIDTH, 32'hFFFFFFFD);
    pulse_pos(0);
    #1 check(32'(in_position_output), 32'h0);
    await_lvl(in_position_output, 1'b1);
    check(32'(n >= 3 * TK - 2 && n <= 3 * TK + 3), 32'h1);
    cyc(5);
    check(32'(in_position_output), 32'h1);
    wr(OFF_CPL_WIDTH, 32'h0);
    pulse_pos(1);
    repeat (6) begin
      @(posedge ref_clk) err_ok <= 1'($random(seed));
      cyc(2);
      check(32'(in_position_output), 32'(err_ok));
    end
    @(posedge ref_clk) err_ok <= 1'b1;
    wr(OFF_OUT_POL, 32'h1);
    cyc(2);
    check(32'(in_position_output), 32'h0);
    rd(OFF_MONITOR, 32'h100, 32'h100);
    @(posedge ref_clk) err_mag <= 24'h64;
    wr(OFF_GAIN_DELAY, 32'h2);
    wr(OFF_GAIN_THR, 32'h64);
    await_lvl(stat, 1'b1);
    check(32'(n >= 2 * TK && n <= 2 * TK + 3), 32'h1);
    wr(OFF_GAIN_THR, 32'h280000);
    cyc(2);
    check(32'(stat), 32'h1);
    @(posedge ref_clk) err_mag <= 24'hFFFFFF;
    cyc(3);
    check(32'(stat), 32'h0);
    @(posedge ref_clk) err_mag <= 24'h0;
    wr(OFF_GAIN_THR, 32'h0);
    cyc(20);
    check(32'(stat), 32'h0);
    summarize();
  end
endmodule
bind sgs_status sgs_status_asserts u_chk (.ref_clk_in, .rst_in,
  .avs_read_in, .avs_write_in, .avs_readdata_out, .avs_waitrequest_out,
  .index_pulse_in, .index_msb_in, .phase_z_out, .pos_err_mag_in,
  .stationary_gain_out, .home_accel_out, .home_decel_eff_out);
`default_nettype wire
